// ---- verilog/dac_dma_pkg.sv ----
`default_nettype none
package dac_dma_pkg;
  // byte addresses of the register words
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_CMP0      = 8'h04;
  localparam logic [7:0] OFS_CMP1      = 8'h08;
  localparam logic [7:0] OFS_SRC_A     = 8'h0C;
  localparam logic [7:0] OFS_SRC_B     = 8'h10;
  localparam logic [7:0] OFS_CNT_A     = 8'h14;
  localparam logic [7:0] OFS_CNT_B     = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h20;
  localparam logic [7:0] OFS_STATUS    = 8'h24;
  localparam logic [7:0] OFS_DATA0     = 8'h28;
  localparam logic [7:0] OFS_DATA1     = 8'h2C;
  // control register bit positions
  localparam int B_START0   = 0;
  localparam int B_START1   = 1;
  localparam int B_SYNC     = 2;
  localparam int B_SYNCCLR0 = 3;
  localparam int B_CLRCMP1  = 4;
  localparam int B_XFER_A   = 5;
  localparam int B_XFER_B   = 6;
  localparam int B_TEND_IE  = 7;
  localparam int B_DAC_EN0  = 8;
  localparam int B_DAC_EN1  = 9;
  localparam int B_AUTOCLR  = 10;
  // interrupt status bit positions
  localparam int I_TEND_B = 0;
  localparam int I_CMP0   = 1;
  localparam int I_CMP1   = 2;
  localparam int I_TEND_A = 3;
  localparam int IRQ_W    = 4;
  // reset values
  localparam logic [15:0] CMP_RESET  = 16'hFFFF;
  localparam logic [15:0] CNT_RESET  = 16'h001F;
  localparam logic [23:0] SRC_A_RST  = 24'hFF_7C10;
  localparam logic [23:0] SRC_B_RST  = 24'hFF_7C30;
  localparam logic [23:0] RAM_BASE   = 24'hFF_7C10;
  localparam int          RAM_BYTES  = 64;
  // conversion time
  localparam int          CLK_NS     = 50;
  localparam int          CONV_NS    = 10000;
  localparam int          CONV_CYC   = (CONV_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_RUN  = 2'b01,
    CH_DONE = 2'b10
  } ch_state_t;
endpackage
`default_nettype wire

// ---- verilog/dac_dma_playback.sv ----
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - each compare-A match of a running sub-channel moves the next buffer byte into converter data
// - sync mode makes both timers count in lockstep
// - timer1 clears at compare A; timer0 with sync clear clears together
// - timer1 compare A sets the sample period on the core clock; timer0 follows it only through sync clear
// - data write starts conversion; output appears after conversion time
// - a match that triggers a transfer does not set that timer's compare interrupt
// - sub-channel B flags transfer end when count exhausted and enabled
// - fixed destinations per sub-channel, source advances one byte
// - timers count only while their start bits are set
// - converter drives its output only while enabled
// - each sub-channel performs count+1 single-byte transfers per run, 32 with the reset count
module dac_dma_playback
  import dac_dma_pkg::*;
#(
  parameter int CONV_CYCLES = dac_dma_pkg::CONV_CYC
) (
  input  wire logic        CORE_CLK,   // 20 mhz core clock
  input  wire logic        SRST,       // sync reset, high
  input  wire logic        PSEL,       // apb select
  input  wire logic        PENABLE,    // apb access phase
  input  wire logic        PWRITE,     // apb write
  input  wire logic [7:0]  PADDR,      // apb byte address
  input  wire logic [31:0] PWDATA,     // apb write data
  output logic      [31:0] PRDATA,     // apb read data
  output logic             PREADY,     // apb ready
  output logic             PSLVERR,    // apb error
  output logic      [7:0]  ANALOG_OUT_ZERO, // converter 0 output code
  output logic      [7:0]  ANALOG_OUT_ONE,  // converter 1 output code
  output logic             ANALOG_OE_ZERO,  // converter 0 drives pin
  output logic             ANALOG_OE_ONE,   // converter 1 drives pin
  output logic             IRQ         // level interrupt
);
  import dac_dma_pkg::*;

  logic [10:0] ctrl;
  logic [15:0] timer0_compare_a, timer1_compare_a;
  logic [15:0] timer0_counter, timer1_counter;
  logic [23:0] src [2];
  logic [15:0] cnt [2];
  ch_state_t   st  [2];
  logic [7:0]  ram [RAM_BYTES];
  logic [7:0]  dac_data [2];
  logic [15:0] conv_cnt [2];
  // one element per channel: each is owned by its own generate process
  logic        conv_busy [2];
  logic [1:0]  data_wr;
  logic [IRQ_W-1:0] irq_stat, irq_mask;
  logic [1:0]  match;
  logic [1:0]  xfer_go;
  logic [1:0]  xfer_en;
  logic        wr_en, rd_en;
  logic [IRQ_W-1:0] next_irq_stat;

  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign rd_en   = PSEL && PENABLE && !PWRITE;
  assign xfer_en = {ctrl[B_XFER_B], ctrl[B_XFER_A]};

  // apb: zero wait states, single-cycle access
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= 1'b0;
    end
  end

  assign match[0] = (timer0_counter == timer0_compare_a);
  assign match[1] = (timer1_counter == timer1_compare_a);

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      timer0_counter <= 16'h0000;
      timer1_counter <= 16'h0000;
    end else begin
      if (ctrl[B_START1]) begin
        if (ctrl[B_CLRCMP1] && match[1])
          timer1_counter <= 16'h0000;
        else
          timer1_counter <= timer1_counter + 16'h0001;
      end
      // lockstep: sync ties timer0 to timer1 start
      if (ctrl[B_START0] && (!ctrl[B_SYNC] || ctrl[B_START1])) begin
        if (ctrl[B_SYNC] && ctrl[B_SYNCCLR0] && ctrl[B_CLRCMP1]
            && match[1])
          timer0_counter <= 16'h0000;
        else
          timer0_counter <= timer0_counter + 16'h0001;
      end
    end
  end

  // counters run only when enabled; gate events accordingly
  logic [1:0] evt;
  assign evt[0] = match[0] && ctrl[B_START0];
  assign evt[1] = match[1] && ctrl[B_START1];

  // one generate loop, one iteration per sub-channel
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      assign xfer_go[g] = evt[g] && (st[g] == CH_RUN);
      assign data_wr[g] = wr_en
                          && (PADDR == (g == 0 ? OFS_DATA0 : OFS_DATA1));

      always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
          st[g] <= CH_IDLE;
        end else begin
          case (st[g])
            CH_IDLE: begin
              if (xfer_en[g])
                st[g] <= CH_RUN;
            end
            CH_RUN: begin
              if (!xfer_en[g])
                st[g] <= CH_IDLE;
              else if (xfer_go[g] && cnt[g] == 16'h0000)
                st[g] <= CH_DONE;
            end
            CH_DONE: begin
              if (!xfer_en[g])
                st[g] <= CH_IDLE;
            end
            default: st[g] <= CH_IDLE;
          endcase
        end
      end

      // fixed destination, source steps one byte
      always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
          dac_data[g] <= 8'h00;
        end else if (xfer_go[g]) begin
          dac_data[g] <= ram[6'(src[g] - RAM_BASE)];
        end else if (data_wr[g]) begin
          dac_data[g] <= PWDATA[7:0];
        end
      end

      // conversion timer restarts on each data write
      always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
          conv_cnt[g]  <= 16'h0000;
          conv_busy[g] <= 1'b0;
        end else if (xfer_go[g] || data_wr[g]) begin
          conv_cnt[g]  <= 16'(CONV_CYCLES - 1);
          conv_busy[g] <= 1'b1;
        end else if (conv_busy[g]) begin
          if (conv_cnt[g] == 16'h0000)
            conv_busy[g] <= 1'b0;
          else
            conv_cnt[g] <= conv_cnt[g] - 16'h0001;
        end
      end
    end
  endgenerate

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ANALOG_OUT_ZERO <= 8'h00;
      ANALOG_OUT_ONE  <= 8'h00;
      ANALOG_OE_ZERO  <= 1'b0;
      ANALOG_OE_ONE   <= 1'b0;
    end else begin
      ANALOG_OE_ZERO <= ctrl[B_DAC_EN0];
      ANALOG_OE_ONE  <= ctrl[B_DAC_EN1];
      if (ctrl[B_DAC_EN0] && conv_busy[0] && conv_cnt[0] == 16'h0000)
        ANALOG_OUT_ZERO <= dac_data[0];
      if (ctrl[B_DAC_EN1] && conv_busy[1] && conv_cnt[1] == 16'h0000)
        ANALOG_OUT_ONE <= dac_data[1];
    end
  end

  // software registers, source and count advance
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ctrl             <= 11'h000;
      timer0_compare_a <= CMP_RESET;
      timer1_compare_a <= CMP_RESET;
      src[0]           <= SRC_A_RST;
      src[1]           <= SRC_B_RST;
      cnt[0]           <= CNT_RESET;
      cnt[1]           <= CNT_RESET;
      irq_mask         <= '0;
    end else begin
      if (wr_en) begin
        case (PADDR)
          OFS_CTRL:     ctrl             <= PWDATA[10:0];
          OFS_CMP0:     timer0_compare_a <= PWDATA[15:0];
          OFS_CMP1:     timer1_compare_a <= PWDATA[15:0];
          OFS_SRC_A:    src[0]           <= PWDATA[23:0];
          OFS_SRC_B:    src[1]           <= PWDATA[23:0];
          OFS_CNT_A:    cnt[0]           <= PWDATA[15:0];
          OFS_CNT_B:    cnt[1]           <= PWDATA[15:0];
          OFS_IRQ_MASK: irq_mask         <= PWDATA[IRQ_W-1:0];
          default: ;
        endcase
      end
      for (int i = 0; i < 2; i++) begin
        if (xfer_go[i]) begin
          src[i] <= src[i] + 24'h00_0001;
          cnt[i] <= cnt[i] - 16'h0001;
        end
      end
    end
  end

  // sample buffer written as bytes through a window at 0x80
  always_ff @(posedge CORE_CLK) begin
    if (wr_en && PADDR[7] == 1'b1)
      ram[PADDR[5:0]] <= PWDATA[7:0];
  end

  always_comb begin
    next_irq_stat = irq_stat;
    if (rd_en && PADDR == OFS_IRQ_STAT)
      next_irq_stat = '0;
    // timer irq suppressed when a transfer takes the event
    if (evt[0] && !(xfer_go[0] && ctrl[B_AUTOCLR]))
      next_irq_stat[I_CMP0] = 1'b1;
    if (evt[1] && !(xfer_go[1] && ctrl[B_AUTOCLR]))
      next_irq_stat[I_CMP1] = 1'b1;
    if (xfer_go[0] && cnt[0] == 16'h0000)
      next_irq_stat[I_TEND_A] = 1'b1;
    if (xfer_go[1] && cnt[1] == 16'h0000 && ctrl[B_TEND_IE])
      next_irq_stat[I_TEND_B] = 1'b1;
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      irq_stat <= '0;
      IRQ      <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      IRQ      <= |(next_irq_stat & irq_mask);
    end
  end

  // read mux
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        OFS_CTRL:     PRDATA <= {21'h0, ctrl};
        OFS_CMP0:     PRDATA <= {16'h0, timer0_compare_a};
        OFS_CMP1:     PRDATA <= {16'h0, timer1_compare_a};
        OFS_SRC_A:    PRDATA <= {8'h0, src[0]};
        OFS_SRC_B:    PRDATA <= {8'h0, src[1]};
        OFS_CNT_A:    PRDATA <= {16'h0, cnt[0]};
        OFS_CNT_B:    PRDATA <= {16'h0, cnt[1]};
        OFS_IRQ_STAT: PRDATA <= {28'h0, irq_stat};
        OFS_IRQ_MASK: PRDATA <= {28'h0, irq_mask};
        OFS_STATUS:   PRDATA <= {timer1_counter, timer0_counter};
        OFS_DATA0:    PRDATA <= {22'h0, conv_busy[1], conv_busy[0],
                                 dac_data[0]};
        OFS_DATA1:    PRDATA <= {24'h0, dac_data[1]};
        default:      PRDATA <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- dv/dac_dma_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module dac_dma_monitor #(
  parameter int CONV_CYCLES = 4
) (
  input wire logic        CORE_CLK,        // core clock
  input wire logic        SRST,            // sync reset
  input wire logic        PSEL,            // select
  input wire logic        PENABLE,         // access phase
  input wire logic        PWRITE,          // write
  input wire logic [7:0]  PADDR,           // address
  input wire logic [31:0] PWDATA,          // write data
  input wire logic [31:0] PRDATA,          // read data
  input wire logic        PREADY,          // ready
  input wire logic        PSLVERR,         // error
  input wire logic [7:0]  ANALOG_OUT_ZERO, // code 0
  input wire logic [7:0]  ANALOG_OUT_ONE,  // code 1
  input wire logic        ANALOG_OE_ZERO,  // enable 0
  input wire logic        ANALOG_OE_ONE,   // enable 1
  input wire logic        IRQ              // interrupt
);
  import dac_dma_pkg::*;
  localparam int CONV_DLY  = CONV_CYCLES + 1;
  localparam int CONV_LATE = CONV_CYCLES + 2;
  logic [31:0] ctrl_seen;
  logic [7:0]  data0_seen;
  wire         fin = PSEL && PENABLE && PREADY;
  always_ff @(posedge CORE_CLK) begin
    if (fin && PWRITE && PADDR == OFS_CTRL) begin
      ctrl_seen <= PWDATA;
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (fin && PWRITE && PADDR == OFS_DATA0) begin
      data0_seen <= PWDATA[7:0];
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_wr_data0;
    fin && PWRITE && PADDR == OFS_DATA0 && ANALOG_OE_ZERO;
  endsequence
  a_ready_next: assert property (s_setup |=> PREADY)
    else $error("no ready after setup");
  a_ready_pulse: assert property (PREADY |-> PSEL && PENABLE ##1 !PREADY)
    else $error("ready outside access");
  a_no_error: assert property (!PSLVERR)
    else $error("slave error raised");
  a_unmapped_zero: assert property (fin && !PWRITE
    && PADDR inside {[8'h30:8'h7F]} |-> PRDATA == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_conv_wait: assert property (s_wr_data0 |=> $stable(ANALOG_OUT_ZERO)[*4])
    else $error("output before conversion time");
  a_conv_result: assert property (s_wr_data0 |->
    ##[CONV_DLY:CONV_LATE] ANALOG_OUT_ZERO == data0_seen)
    else $error("converted code wrong");
  a_idle_hold: assert property (!ANALOG_OE_ONE
    && $past(!ANALOG_OE_ONE) |-> $stable(ANALOG_OUT_ONE))
    else $error("disabled converter changed");
  a_oe_follow: assert property (fin && PWRITE && PADDR == OFS_CTRL
    |-> ##[1:2] (ANALOG_OE_ZERO == ctrl_seen[B_DAC_EN0]
    && ANALOG_OE_ONE == ctrl_seen[B_DAC_EN1]))
    else $error("output enable mismatch");
  a_reset_quiet: assert property (disable iff (1'b0)
    $past(SRST) |-> !IRQ && !PREADY && !ANALOG_OE_ZERO && !ANALOG_OE_ONE)
    else $error("outputs active in reset");
endmodule
bind dac_dma_playback dac_dma_monitor #(.CONV_CYCLES(CONV_CYCLES)) u_mon (
  .CORE_CLK(CORE_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .ANALOG_OUT_ZERO(ANALOG_OUT_ZERO),
  .ANALOG_OUT_ONE(ANALOG_OUT_ONE), .ANALOG_OE_ZERO(ANALOG_OE_ZERO),
  .ANALOG_OE_ONE(ANALOG_OE_ONE), .IRQ(IRQ));
`default_nettype wire

// ---- dv/dac_pin_sink.sv ----
`timescale 1ns/1ns
`default_nettype none
module dac_pin_sink (
  input  wire logic       clk,     // core clock
  input  wire logic [7:0] code,    // converter code
  input  wire logic       oe,      // pin driven
  output var  int         updates  // new codes seen
);
  logic [7:0] last;
  initial updates = 0;
  // a pin only counts while driven
  always @(posedge clk) begin
    if (oe && code !== last) begin
      updates <= updates + 1;
    end
    last <= code;
  end
endmodule
`default_nettype wire

// ---- dv/timer_paced_dac_dma_playback_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module timer_paced_dac_dma_playback_tb_top;
  import dac_dma_pkg::*;
  localparam int CONVC = 4;
  logic CORE_CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, OE0, OE1;
  logic [7:0]  PADDR, OUT0, OUT1, b0;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [7:0]  ram [64];
  int          mismatches, compares, upd0, upd1, per, n;
  logic        done_flag;
  dac_dma_playback #(.CONV_CYCLES(CONVC)) u_dut (.CORE_CLK(CORE_CLK),
    .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .ANALOG_OUT_ZERO(OUT0), .ANALOG_OUT_ONE(OUT1),
    .ANALOG_OE_ZERO(OE0), .ANALOG_OE_ONE(OE1), .IRQ(IRQ));
  dac_pin_sink u_s0 (.clk(CORE_CLK), .code(OUT0), .oe(OE0), .updates(upd0));
  dac_pin_sink u_s1 (.clk(CORE_CLK), .code(OUT1), .oe(OE1), .updates(upd1));
  initial begin
    CORE_CLK = 1'b0;
    forever #25 CORE_CLK = ~CORE_CLK;
  end
  function automatic int exp_gap(input int cmp);
    return cmp + 1;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int c);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    repeat (c) @(posedge CORE_CLK);
  endtask
  // leaves the bus held: caller follows with apb or idle at once
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 20);
    rd = PRDATA;
    if (k >= 20) mismatches++;
  endtask
  task automatic results;
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    mismatches++;
    results();
  end
  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    SRST = 1'b1;
    mismatches = 0;
    compares = 0;
    done_flag = 1'b0;
    void'($urandom(32'h6138_5815));
    repeat (4) @(posedge CORE_CLK);
    SRST <= 1'b0;
    // no stop state: blocks are live once reset is released
    apb(1'b0, OFS_CMP0, 32'h0000_0000);
    chk(rd, 32'h0000_FFFF);
    apb(1'b0, OFS_SRC_B, 32'h0000_0000);
    chk(rd, 32'h00FF_7C30);
    apb(1'b0, OFS_CNT_B, 32'h0000_0000);
    chk(rd, 32'h0000_001F);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b1, OFS_CTRL, 32'h0000_0100);
    apb(1'b1, OFS_DATA0, 32'h0000_00A5);
    apb(1'b1, OFS_DATA1, 32'h0000_005A);
    idle(CONVC + 4);
    chk(32'(OUT0), 32'h0000_00A5);
    chk(32'(OUT1), 32'h0000_0000);
    b0 = 8'hA5;
    // consecutive bytes differ so every transfer shows on the pin
    for (int i = 0; i < 64; i++) begin
      ram[i] = 8'($urandom);
      if (i == 32) b0 = 8'h00;
      if (ram[i] == b0) ram[i] = ~ram[i];
      b0 = ram[i];
      apb(1'b1, 8'h80 + 8'(i), 32'(ram[i]));
    end
    per = 8 + int'($urandom % 8);
    apb(1'b1, OFS_CMP0, 32'(per));
    apb(1'b1, OFS_CMP1, 32'(per));
    apb(1'b1, OFS_CNT_A, 32'h0000_001F);
    apb(1'b1, OFS_CNT_B, 32'h0000_001F);
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
    apb(1'b1, OFS_CTRL, 32'h0000_07FF);
    idle(1);
    b0 = 8'hA5;
    for (int i = 0; i < 32; i++) begin
      n = 0;
      while (OUT0 === b0 && n < 100) begin
        @(posedge CORE_CLK);
        n++;
      end
      b0 = OUT0;
      chk(32'(OUT0), 32'(ram[i]));
      chk(32'(OUT1), 32'(ram[32 + i]));
      if (i > 0) chk(32'(n), 32'(exp_gap(per)));
      if (i < 31) chk(32'(IRQ), 32'h0000_0000);
    end
    done_flag = IRQ;
    chk(32'(done_flag), 32'h0000_0001);
    // read before the next match: later matches find no transfer
    apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
    chk(rd & 32'h0000_0007, 32'h0000_0001);
    idle(4 * per);
    chk(32'(OUT0), 32'(ram[31]));
    chk(32'(upd0), 32'd33);
    chk(32'(upd1), 32'd32);
    chk(32'(IRQ), 32'h0000_0000);
    apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
    idle(1);
    chk(rd & 32'h0000_0001, 32'h0000_0000);
    chk(rd & 32'h0000_0006, 32'h0000_0006);
    results();
  end
endmodule
`default_nettype wire
